// >>> pkg/addr_gen_pkg.sv
// Shared constants and types for the circular and bit-reversed address generator.
// Assumes a 16-bit data address space and one synchronous core clock.
package addr_gen_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int AW      = 16;
  localparam int ADR_W   = 8;
  localparam int DW      = 32;
  localparam int SEL_W   = 4;
  localparam int PIVOT_W = 15;
  localparam int NREG    = 6;
  localparam int IDX_W   = 3;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_X_START = 3'h0;
  localparam logic [IDX_W-1:0] IDX_X_END   = 3'h1;
  localparam logic [IDX_W-1:0] IDX_Y_START = 3'h2;
  localparam logic [IDX_W-1:0] IDX_Y_END   = 3'h3;
  localparam logic [IDX_W-1:0] IDX_CTRL    = 3'h4;
  localparam logic [IDX_W-1:0] IDX_REV     = 3'h5;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int X_SEL_LSB  = 0;
  localparam int Y_SEL_LSB  = 4;
  localparam int R_SEL_LSB  = 8;
  localparam int X_EN_BIT   = 15;
  localparam int Y_EN_BIT   = 14;
  localparam int REV_EN_BIT = 15;
  localparam int ST_XMOD    = 0;
  localparam int ST_YMOD    = 1;
  localparam int ST_REV     = 2;
  localparam int ST_WRAP    = 3;
  localparam int ST_BREV    = 4;

  // Select value that switches a unit off
  localparam logic [SEL_W-1:0] SEL_OFF = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] BUF_RST  = 16'h0000;
  localparam logic [AW-1:0] CTRL_RST = 16'h0fff;
  localparam logic [AW-1:0] REV_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AM_INDIRECT, AM_POST_MOD, AM_PRE_MOD, AM_REG_OFFSET} addr_mode_t;
  typedef enum logic [1:0] {SP_X_READ, SP_X_WRITE, SP_Y} space_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_t;

endpackage : addr_gen_pkg

// >>> core/modulo_wrap.sv
// Circular buffer boundary test and wrap for one address space.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module modulo_wrap
  import addr_gen_pkg::*;
(
  // Candidate address and direction
  input  wire logic [AW-1:0] i_addr,
  input  wire logic          i_inc,
  input  wire logic          i_dec,
  input  wire logic          i_word,
  // Buffer bounds
  input  wire logic [AW-1:0] i_start,
  input  wire logic [AW-1:0] i_end,
  // Result
  output logic      [AW-1:0] o_addr,
  output logic               o_wrapped
);
  import addr_gen_pkg::*;

  // One extra bit so a full 64 Kbyte buffer length does not fold to zero
  wire logic [AW:0]   len      = {1'b0, i_end} - {1'b0, i_start} + 17'h00001;
  wire logic [AW:0]   len_m1   = len - 17'h00001;
  wire logic          pow2     = (len & len_m1) == 17'h00000;
  wire logic          chk_hi   = i_inc | pow2;                                 // RULE_03 RULE_10
  wire logic          chk_lo   = i_dec | pow2;                                 // RULE_03 RULE_10
  wire logic          wrap_hi  = chk_hi & (i_addr > i_end);                    // RULE_11
  wire logic          wrap_lo  = chk_lo & (i_addr < i_start);                  // RULE_11
  wire logic [AW-1:0] wrapped  = wrap_hi ? i_addr - len[AW-1:0]                // RULE_23
                                         : i_addr + len[AW-1:0];               // RULE_23
  wire logic [AW-1:0] sel_addr = (wrap_hi | wrap_lo) ? wrapped : i_addr;

  assign o_addr    = {sel_addr[AW-1:1], sel_addr[0] & ~i_word};
  assign o_wrapped = wrap_hi | wrap_lo;

endmodule : modulo_wrap

// >>> core/reverse_carry_add.sv
// Reverse-carry adder: carries ripple from the top bit toward bit zero.
// The pointer stays in normal order; only the modifier acts reversed.
`timescale 1ns/1ps
module reverse_carry_add
  import addr_gen_pkg::*;
(
  // Operands
  input  wire logic [AW-1:0] i_ptr,
  input  wire logic [AW-1:0] i_mod,
  // Sum with the lsb cleared for word access
  output logic      [AW-1:0] o_sum
);
  import addr_gen_pkg::*;

  logic [AW-1:0] ptr_rev;
  logic [AW-1:0] mod_rev;
  logic [AW-1:0] sum_rev;
  logic [AW-1:0] sum_nrm;

  genvar b;
  generate
    for (b = 0; b < AW; b++)
    begin : g_rev
      assign ptr_rev[b] = i_ptr[AW-1-b];
      assign mod_rev[b] = i_mod[AW-1-b];
      assign sum_nrm[b] = sum_rev[AW-1-b];
    end
  endgenerate

  assign sum_rev = ptr_rev + mod_rev;                                          // RULE_14
  assign o_sum   = {sum_nrm[AW-1:1], 1'b0};                                    // RULE_20

endmodule : reverse_carry_add

// >>> core/modulo_bitrev_address_gen.sv
// Effective-address post-processing: circular wrap for X and Y pointers and
// bit-reversed modification on X writes, plus a classic Wishbone register slave.
// Assumes requests arrive from core logic on i_clk, one per enabled cycle.
//
// Overview of operation
// (RULE_01) One circular buffer in X space and one in Y space, set up separately.
// (RULE_02) Software should not use the stack frame or stack pointer as circular pointer.
// (RULE_03) Power-of-two buffers are tested at both ends, allowing either direction.
// (RULE_04) Buffers bounded by 16-bit start and end registers, length up to 32K words.
// (RULE_05) Y circular addresses are word addresses with bit zero forced clear.
// (RULE_06) X select field of 15 turns circular wrap off for X read and write.
// (RULE_07) X select in control bits 3:0; X active only with enable bit 15 set.
// (RULE_08) Y select in control bits 7:4; Y active only with enable bit 14 set.
// (RULE_09) Wrap applies to whichever working register the select field names.
// (RULE_10) Incrementing pointers test the upper bound, decrementing ones the lower bound.
// (RULE_11) Addresses stepping past a bound are caught and wrapped correctly too.
// (RULE_12) Corrected pointer written back only in pre or post modify modes.
// (RULE_13) Bit-reversed modification only in the X write generator.
// (RULE_14) Only the modifier is bit-reversed; pointer stays in normal order.
// (RULE_15) Bit reversal needs select not 15, enable set, pre or post increment.
// (RULE_16) Software aligns a 2^N byte reversed buffer on its low N bits.
// (RULE_17) Pivot is bits 14:0 of the reverse carry control register.
// (RULE_18) Pivot is scaled to byte addresses, bit zero always clear.
// (RULE_19) Other modes or byte writes get normal addresses even when enabled.
// (RULE_20) When active, pointer plus reversed pivot; normal increment ignored; lsb zero.
// (RULE_21) Bit reversal overrides X write wrap; X read wrap keeps working.
// (RULE_22) Software avoids a reversed read right after rewriting the reverse register.
// (RULE_23) Crossing a bound wraps by buffer length back into the buffer.
`timescale 1ns/1ps
module modulo_bitrev_address_gen
  import addr_gen_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  // Wishbone slave
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [addr_gen_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [addr_gen_pkg::DW-1:0]    i_wb_dat,
  input  wire logic [3:0]                i_wb_sel,
  output logic      [addr_gen_pkg::DW-1:0]    o_wb_dat,
  output logic                           o_wb_ack,
  // Address request from execution logic
  input  wire logic                      i_req_valid,
  input  wire addr_gen_pkg::space_t      i_req_space,
  input  wire addr_gen_pkg::addr_mode_t  i_req_mode,
  input  wire logic [addr_gen_pkg::SEL_W-1:0] i_req_wreg,
  input  wire logic [addr_gen_pkg::AW-1:0]    i_req_ptr,
  input  wire logic [addr_gen_pkg::AW-1:0]    i_req_mod,
  input  wire logic                      i_req_byte,
  // Result
  output logic                           o_ea_valid,
  output logic      [addr_gen_pkg::AW-1:0]    o_ea,
  output logic                           o_ptr_wr_valid,
  output logic      [addr_gen_pkg::SEL_W-1:0] o_ptr_wr_reg,
  output logic      [addr_gen_pkg::AW-1:0]    o_ptr_wr_value,
  output logic                           o_wrapped,
  output logic                           o_reversed
);
  import addr_gen_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] REG_RST [NREG] = '{BUF_RST, BUF_RST, BUF_RST, BUF_RST, CTRL_RST, REV_RST};

  logic       [AW-1:0]    cfg [NREG];
  bus_state_t             bus_state;
  bus_state_t             next_bus_state;
  logic       [4:0]       status;

  wire logic              bus_req  = i_wb_cyc & i_wb_stb & (bus_state == BUS_IDLE);
  wire logic [IDX_W-1:0]  reg_idx  = i_wb_adr[IDX_W+1:2];
  wire logic              adr_ok   = (i_wb_adr[1:0] == 2'b00) && (i_wb_adr[ADR_W-1:IDX_W+2] == '0);
  wire logic              wr_go    = i_ce & bus_req & i_wb_we & adr_ok;

  wire logic [AW-1:0] x_buffer_start_addr   = cfg[IDX_X_START];                 // RULE_04
  wire logic [AW-1:0] x_buffer_end_addr     = cfg[IDX_X_END];                   // RULE_04
  wire logic [AW-1:0] y_buffer_start_addr   = cfg[IDX_Y_START];                 // RULE_04
  wire logic [AW-1:0] y_buffer_end_addr     = cfg[IDX_Y_END];                   // RULE_04
  wire logic [AW-1:0] circular_addr_control = cfg[IDX_CTRL];
  wire logic [AW-1:0] reverse_carry_control = cfg[IDX_REV];

  genvar r;
  generate
    for (r = 0; r < NREG; r++)
    begin : g_reg
      wire logic hit = wr_go && (reg_idx == IDX_W'(r));
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          cfg[r] <= REG_RST[r];
        else if (hit)
        begin
          if (i_wb_sel[0]) cfg[r][7:0]  <= i_wb_dat[7:0];
          if (i_wb_sel[1]) cfg[r][15:8] <= i_wb_dat[15:8];
        end
      end
    end
  endgenerate

  // Unmapped or misaligned addresses read zero and still acknowledge
  wire logic [AW-1:0] rd_word = !adr_ok                  ? '0 :
                                (reg_idx == IDX_STATUS)  ? {11'h000, status} :
                                (reg_idx < IDX_STATUS)   ? cfg[reg_idx] : '0;

  assign next_bus_state = (bus_state == BUS_IDLE && bus_req) ? BUS_ACK : BUS_IDLE;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_state <= BUS_IDLE;
      o_wb_ack  <= 1'b0;
      o_wb_dat  <= '0;
    end
    else if (i_ce)
    begin
      case (bus_state)
        BUS_IDLE: bus_state <= next_bus_state;
        BUS_ACK:  bus_state <= next_bus_state;
        default:  bus_state <= BUS_IDLE;
      endcase
      o_wb_ack <= bus_req;
      o_wb_dat <= {16'h0000, rd_word};
    end
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire logic [SEL_W-1:0] x_pointer_select       = circular_addr_control[X_SEL_LSB +: SEL_W];
  wire logic [SEL_W-1:0] y_pointer_select       = circular_addr_control[Y_SEL_LSB +: SEL_W];
  wire logic [SEL_W-1:0] reverse_pointer_select = circular_addr_control[R_SEL_LSB +: SEL_W];
  wire logic             x_circular_enable      = circular_addr_control[X_EN_BIT];
  wire logic             y_circular_enable      = circular_addr_control[Y_EN_BIT];
  wire logic             reverse_enable         = reverse_carry_control[REV_EN_BIT];
  wire logic [PIVOT_W-1:0] reverse_pivot        = reverse_carry_control[PIVOT_W-1:0];  // RULE_17

  wire logic x_mod_on = x_circular_enable && (x_pointer_select != SEL_OFF);    // RULE_06 RULE_07
  wire logic y_mod_on = y_circular_enable && (y_pointer_select != SEL_OFF);    // RULE_08
  wire logic rev_on   = reverse_enable && (reverse_pointer_select != SEL_OFF); // RULE_15

  // ----------------------------------------------------------------
  // Request datapath
  // ----------------------------------------------------------------
  wire logic is_y     = (i_req_space == SP_Y);
  wire logic is_xw    = (i_req_space == SP_X_WRITE);
  wire logic mod_pos  = ~i_req_mod[AW-1] & (i_req_mod != '0);
  wire logic mod_neg  = i_req_mod[AW-1];
  wire logic premod   = (i_req_mode == AM_PRE_MOD);
  wire logic postmod  = (i_req_mode == AM_POST_MOD);
  wire logic offs     = (i_req_mode == AM_REG_OFFSET);
  wire logic moves    = premod | postmod | offs;

  // Reversal only on word writes in the X write unit with an increment
  wire logic brev_now = rev_on & is_xw & ~i_req_byte & mod_pos                 // RULE_13 RULE_19
                        & (premod | postmod) & (i_req_wreg == reverse_pointer_select);  // RULE_15

  // Reversal pre-empts wrap in the write unit only; X read keeps it
  wire logic sel_hit  = is_y ? (i_req_wreg == y_pointer_select)                // RULE_09
                             : (i_req_wreg == x_pointer_select);
  wire logic mod_now  = moves & sel_hit & ~brev_now                            // RULE_21
                        & (is_y ? y_mod_on : x_mod_on);                        // RULE_01

  wire logic [AW-1:0] raw_sum   = i_req_ptr + i_req_mod;
  wire logic [AW-1:0] win_start = is_y ? y_buffer_start_addr : x_buffer_start_addr;  // RULE_01
  wire logic [AW-1:0] win_end   = is_y ? y_buffer_end_addr   : x_buffer_end_addr;
  wire logic [AW-1:0] pivot_b   = {reverse_pivot, 1'b0};                       // RULE_18
  wire logic [AW-1:0] wrap_addr;
  wire logic          wrap_hit;
  wire logic [AW-1:0] rev_addr;

  modulo_wrap i_modulo_wrap (
    .i_addr    (raw_sum),
    .i_inc     (mod_pos),
    .i_dec     (mod_neg),
    .i_word    (is_y),                                                         // RULE_05
    .i_start   (win_start),
    .i_end     (win_end),
    .o_addr    (wrap_addr),
    .o_wrapped (wrap_hit)
  );

  reverse_carry_add i_reverse_carry_add (
    .i_ptr (i_req_ptr),
    .i_mod (pivot_b),                                                          // RULE_20
    .o_sum (rev_addr)
  );

  wire logic [AW-1:0] new_ptr  = brev_now ? rev_addr :                         // RULE_20
                                 mod_now  ? wrap_addr : raw_sum;
  wire logic [AW-1:0] ptr_lsb0 = {i_req_ptr[AW-1:1], 1'b0};
  wire logic [AW-1:0] next_ea  = (premod | offs) ? new_ptr :
                                 brev_now        ? ptr_lsb0 : i_req_ptr;
  wire logic          next_wb  = premod | postmod;                             // RULE_12

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ea_valid     <= 1'b0;
      o_ea           <= '0;
      o_ptr_wr_valid <= 1'b0;
      o_ptr_wr_reg   <= '0;
      o_ptr_wr_value <= '0;
      o_wrapped      <= 1'b0;
      o_reversed     <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ea_valid     <= i_req_valid;
      o_ptr_wr_valid <= i_req_valid & next_wb;                                 // RULE_12
      o_wrapped      <= i_req_valid & mod_now & wrap_hit;                      // RULE_23
      o_reversed     <= i_req_valid & brev_now;
      if (i_req_valid)
      begin
        o_ea           <= next_ea;
        o_ptr_wr_reg   <= i_req_wreg;
        o_ptr_wr_value <= new_ptr;
      end
    end
  end

  // Sticky-free status snapshot: live enables plus last result flags
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      status <= '0;
    else if (i_ce)
    begin
      status[ST_XMOD] <= x_mod_on;
      status[ST_YMOD] <= y_mod_on;
      status[ST_REV]  <= rev_on;
      if (i_req_valid)
      begin
        status[ST_WRAP] <= mod_now & wrap_hit;
        status[ST_BREV] <= brev_now;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_bus_ack_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_wb_ack && i_ce) |=> !o_wb_ack)
    else $error("bus ack held longer than one cycle");

  a_x_sel_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_06
    (i_ce && i_req_valid && !is_y && x_pointer_select == SEL_OFF && !brev_now && moves)
    |=> (o_ptr_wr_value == $past(raw_sum)) && !o_wrapped)
    else $error("X wrap applied with select off");

  a_y_gate_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_08
    (i_ce && i_req_valid && is_y && !y_circular_enable && offs) |=> o_ea == $past(raw_sum))
    else $error("Y wrap applied while disabled");

  a_y_word_lsb: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
    (i_ce && i_req_valid && is_y && moves && y_mod_on && sel_hit) |=> !o_ptr_wr_value[0])
    else $error("Y circular address has lsb set");

  a_upper_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_11
    (i_ce && i_req_valid && mod_now && mod_pos && raw_sum > win_end)
    |=> o_wrapped && o_ptr_wr_value == ($past(raw_sum - (win_end - win_start + 16'h0001))
                                        & {{(AW-1){1'b1}}, !$past(is_y)}))
    else $error("upper bound crossing not wrapped by buffer length");

  a_offset_no_wb: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_12
    (i_ce && i_req_valid && offs) |=> o_ea_valid && !o_ptr_wr_valid)
    else $error("pointer written back in register offset mode");

  a_rev_result: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_20
    (i_ce && i_req_valid && brev_now) |=> o_reversed && o_ptr_wr_valid && !o_ptr_wr_value[0] && !o_wrapped)
    else $error("reversed result malformed");

  a_rev_byte_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_19
    (i_ce && i_req_valid && (i_req_byte || !is_xw || i_req_mode == AM_INDIRECT)) |=> !o_reversed)
    else $error("reversal applied outside word write increment");

  a_read_keeps_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_21
    (i_ce && i_req_valid && i_req_space == SP_X_READ && rev_on && x_mod_on && sel_hit && moves
     && mod_pos && raw_sum > win_end) |=> o_wrapped)
    else $error("X read wrap lost while reversal enabled");

endmodule : modulo_bitrev_address_gen

// >>> bench/exec_req_model.sv
// Behavioural model of the execution logic that issues address requests.
// Assumes one core clock; every request line changes just after a rising edge.
`timescale 1ns/1ps
module exec_req_model
  import addr_gen_pkg::*;
(
  // Clock
  input  wire logic                         i_clk,
  // Request towards the address generator
  output logic                              o_valid,
  output addr_gen_pkg::space_t              o_space,
  output addr_gen_pkg::addr_mode_t          o_mode,
  output logic      [addr_gen_pkg::SEL_W-1:0] o_wreg,
  output logic      [addr_gen_pkg::AW-1:0]    o_ptr,
  output logic      [addr_gen_pkg::AW-1:0]    o_mod,
  output logic                              o_byte
);
  import addr_gen_pkg::*;

  initial
  begin
    o_valid = 1'b0;
    o_space = SP_X_READ;
    o_mode  = AM_INDIRECT;
    o_wreg  = 4'h0;
    o_ptr   = 16'h0000;
    o_mod   = 16'h0000;
    o_byte  = 1'b0;
  end

  // ----------------------------------------------------------------
  // One request, held for exactly the cycle in which it is taken
  // ----------------------------------------------------------------
  task automatic issue(input space_t sp, input addr_mode_t md, input logic [SEL_W-1:0] wr,
                       input logic [AW-1:0] p, input logic [AW-1:0] m, input logic b);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_space <= sp;
    o_mode  <= md;
    o_wreg  <= wr;
    o_ptr   <= p;
    o_mod   <= m;
    o_byte  <= b;
    @(posedge i_clk);
    o_valid <= 1'b0;
    // Released operands show the inverse so stale values are never mistaken for live ones
    o_ptr   <= ~p;
    o_mod   <= ~m;
  endtask : issue
endmodule : exec_req_model

// >>> bench/modulo_bitrev_address_gen_tb.sv
// Self-checking bench: Wishbone register access and address requests with expected results.
// Assumes the package constants and a 100 MHz core clock; clock enable stays high.
`timescale 1ns/1ps
module modulo_bitrev_address_gen_tb;
  import addr_gen_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [DW-1:0] wdat = 32'h0, rdat;
  logic [3:0] sel = 4'h0;
  logic [DW-1:0] o_wb_dat;
  logic o_wb_ack, rv, ea_v, wb_v, wrp, rev, byt;
  space_t sp;
  addr_mode_t md;
  logic [SEL_W-1:0] wreg, wb_reg;
  logic [AW-1:0] ptr, mdf, ea, wb_val;
  int err_total = 0, cmp_count = 0, cyc_cnt = 0;
  localparam logic [AW-1:0] BR_IN [4] = '{16'h0000, 16'h0010, 16'h0008, 16'h0018};
  localparam logic [AW-1:0] BR_OUT[4] = '{16'h0010, 16'h0008, 16'h0018, 16'h0004};

  always #5 clk = ~clk;

  modulo_bitrev_address_gen i_modulo_bitrev_address_gen (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_req_valid(rv), .i_req_space(sp), .i_req_mode(md),
    .i_req_wreg(wreg), .i_req_ptr(ptr), .i_req_mod(mdf), .i_req_byte(byt), .o_ea_valid(ea_v),
    .o_ea(ea), .o_ptr_wr_valid(wb_v), .o_ptr_wr_reg(wb_reg), .o_ptr_wr_value(wb_val),
    .o_wrapped(wrp), .o_reversed(rev));
  exec_req_model i_exec_req_model (.i_clk(clk), .o_valid(rv), .o_space(sp), .o_mode(md),
    .o_wreg(wreg), .o_ptr(ptr), .o_mod(mdf), .o_byte(byt));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // A hang costs a mismatch; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Classic Wishbone cycle: hold until ack is sampled, then release
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do @(posedge clk); while (o_wb_ack !== 1'b1);
    rdat = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [ADR_W-1:0] a, input logic [DW-1:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rdchk

  // Request and compare the result outputs in the cycle they stand; write-back value and register only when a write-back is expected
  task automatic rq(input space_t s, input addr_mode_t m, input logic [SEL_W-1:0] r,
                    input logic [AW-1:0] p, input logic [AW-1:0] d, input logic b,
                    input logic [AW-1:0] xea, input logic xwv, input logic [AW-1:0] xwb,
                    input logic xwrap, input logic xrev);
    i_exec_req_model.issue(s, m, r, p, d, b);
    #1;
    chk(ea_v, 1'b1);
    chk(ea, xea);
    chk(wb_v, xwv);
    if (xwv)
    begin
      chk(wb_val, xwb);
      chk(wb_reg, r);
    end
    chk(wrp, xwrap);
    chk(rev, xrev);
  endtask : rq

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'h10, 32'h0000_0fff);
    rdchk(8'h00, 32'h0);
    rdchk(8'h14, 32'h0);
    rdchk(8'h1c, 32'h0);
    wb(1'b1, 8'h00, 32'h1100);
    wb(1'b1, 8'h04, 32'h1163);
    rdchk(8'h04, 32'h1163);
    wb(1'b1, 8'h10, 32'h8ff1);
    rq(SP_X_READ, AM_POST_MOD, 4'h1, 16'h1162, 16'h0002, 1'b0, 16'h1162, 1, 16'h1100, 1, 0);
    rq(SP_X_WRITE, AM_POST_MOD, 4'h1, 16'h1162, 16'h0004, 1'b0, 16'h1162, 1, 16'h1102, 1, 0);
    rq(SP_X_READ, AM_PRE_MOD, 4'h1, 16'h1100, 16'hfffe, 1'b0, 16'h1162, 1, 16'h1162, 1, 0);
    rq(SP_X_READ, AM_REG_OFFSET, 4'h1, 16'h1162, 16'h0002, 1'b0, 16'h1100, 0, 16'h0, 1, 0);
    rq(SP_X_READ, AM_POST_MOD, 4'h2, 16'h1162, 16'h0002, 1'b0, 16'h1162, 1, 16'h1164, 0, 0);
    rq(SP_X_READ, AM_POST_MOD, 4'h1, 16'h1110, 16'h0002, 1'b0, 16'h1110, 1, 16'h1112, 0, 0);
    wb(1'b1, 8'h10, 32'h0ff1);
    rq(SP_X_READ, AM_POST_MOD, 4'h1, 16'h1162, 16'h0002, 1'b0, 16'h1162, 1, 16'h1164, 0, 0);
    wb(1'b1, 8'h10, 32'h8fff);
    rq(SP_X_READ, AM_POST_MOD, 4'hf, 16'h1162, 16'h0002, 1'b0, 16'h1162, 1, 16'h1164, 0, 0);
    rq(SP_X_WRITE, AM_POST_MOD, 4'hf, 16'h1162, 16'h0002, 1'b0, 16'h1162, 1, 16'h1164, 0, 0);
    // Y buffer of 0x20 bytes, a power of two, so both bounds are live
    wb(1'b1, 8'h08, 32'h2000);
    wb(1'b1, 8'h0c, 32'h201f);
    wb(1'b1, 8'h10, 32'h4f2f);
    rq(SP_Y, AM_POST_MOD, 4'h2, 16'h201e, 16'h0002, 1'b0, 16'h201e, 1, 16'h2000, 1, 0);
    rq(SP_Y, AM_PRE_MOD, 4'h2, 16'h2000, 16'hfffe, 1'b0, 16'h201e, 1, 16'h201e, 1, 0);
    rq(SP_Y, AM_PRE_MOD, 4'h2, 16'h201f, 16'h0002, 1'b0, 16'h2000, 1, 16'h2000, 1, 0);
    rq(SP_X_READ, AM_POST_MOD, 4'h2, 16'h201e, 16'h0002, 1'b0, 16'h201e, 1, 16'h2020, 0, 0);
    // Bit-reversed pointer 3, pivot 8 words; buffer starts at 0 so its low bits are clear
    wb(1'b1, 8'h10, 32'h03ff);
    rq(SP_Y, AM_REG_OFFSET, 4'h2, 16'h201e, 16'h0002, 1'b0, 16'h2020, 0, 16'h0, 0, 0);
    wb(1'b1, 8'h14, 32'h8008);
    rdchk(8'h14, 32'h8008);
    for (int k = 0; k < 4; k++)
      rq(SP_X_WRITE, AM_POST_MOD, 4'h3, BR_IN[k], 16'h0002, 1'b0, BR_IN[k], 1, BR_OUT[k], 0, 1);
    rq(SP_X_WRITE, AM_PRE_MOD, 4'h3, 16'h0018, 16'h0002, 1'b0, 16'h0004, 1, 16'h0004, 0, 1);
    rq(SP_X_WRITE, AM_POST_MOD, 4'h3, 16'h0010, 16'h0001, 1'b1, 16'h0010, 1, 16'h0011, 0, 0);
    rq(SP_X_READ, AM_POST_MOD, 4'h3, 16'h0010, 16'h0002, 1'b0, 16'h0010, 1, 16'h0012, 0, 0);
    rq(SP_X_WRITE, AM_INDIRECT, 4'h3, 16'h0010, 16'h0002, 1'b0, 16'h0010, 0, 16'h0, 0, 0);
    wb(1'b1, 8'h14, 32'h0008);
    rq(SP_X_WRITE, AM_POST_MOD, 4'h3, 16'h0010, 16'h0002, 1'b0, 16'h0010, 1, 16'h0012, 0, 0);
    // Both features on the same pointer; idle cycles follow the register write
    wb(1'b1, 8'h10, 32'h8303);
    wb(1'b1, 8'h14, 32'h8008);
    repeat (2) @(posedge clk);
    rq(SP_X_WRITE, AM_POST_MOD, 4'h3, 16'h1162, 16'h0002, 1'b0, 16'h1162, 1, 16'h1172, 0, 1);
    rq(SP_X_READ, AM_POST_MOD, 4'h3, 16'h1162, 16'h0002, 1'b0, 16'h1162, 1, 16'h1100, 1, 0);
    rdchk(8'h18, 32'h0000_000d);
    finish_test();
  end
endmodule : modulo_bitrev_address_gen_tb
